// ### design/codec_pkg.sv
// Shared constants and carrier types for the codec host port block
package codec_pkg;

  // ************************************************************
  // Sample and FIFO sizes
  // ************************************************************
  localparam int SAMPLE_W   = 32;
  localparam int FIFO_DEPTH = 16;

  // ************************************************************
  // APB register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_INDEX  = 8'h00;
  localparam logic [7:0] OFF_IDATA  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // ************************************************************
  // Indirect register indices
  // ************************************************************
  localparam logic [4:0] IX_FORMAT = 5'h08;
  localparam logic [4:0] IX_CONFIG = 5'h09;
  localparam logic [4:0] IX_MODE   = 5'h0c;
  localparam logic [4:0] IX_MISC   = 5'h10;
  localparam logic [4:0] IX_LINE   = 5'h12;
  localparam logic [4:0] IX_MONO   = 5'h1a;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int B_FMT16    = 0;
  localparam int B_STEREO   = 1;
  localparam int B_PLAY_EN  = 0;
  localparam int B_CAP_EN   = 1;
  localparam int B_ENH      = 6;
  localparam int B_HOLD     = 7;
  localparam int B_LINE_MUT = 7;
  localparam int B_MONO_OUT_MUT = 6;
  localparam int B_MIN_MUT  = 7;

  // ************************************************************
  // Reset values and host port addresses
  // ************************************************************
  localparam logic [7:0] RST_IND  = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h0a; // Id nibble, arbitrary value
  localparam logic [1:0] PIO_DATA = 2'h3;

  // Host parallel port strobes and inputs
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [1:0] addr;
    logic       play_ack_n;
    logic       cap_ack_n;
    logic [7:0] data;
  } host_bus_t;

  // Mixer settings sent to the analog section
  typedef struct packed {
    logic [4:0] line_vol;
    logic       line_mute;
    logic [3:0] mono_att;
    logic       mono_in_mute;
    logic       mono_out_mute;
  } mix_t;

endpackage : codec_pkg

// ### design/sample_fifo.sv
// Synchronous sample FIFO with valid/ready on both sides
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]    level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sample_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0]           mem [DEPTH];
  logic [AW-1:0]              wp_reg, rp_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  wire                        push = in_valid && in_ready;
  wire                        pop  = out_valid && out_ready;

  // Honest flags from the occupancy count
  assign in_ready  = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign level     = cnt_reg;

  // Storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_reg + AW'(push);
      rp_reg  <= rp_reg + AW'(pop);
      cnt_reg <= cnt_reg + $bits(cnt_reg)'(push) - $bits(cnt_reg)'(pop);
    end
  end
endmodule : sample_fifo

// ### design/codec_host_port.sv
// Codec host port: mode, mixer settings, parallel port, sample FIFOs
module codec_host_port
  import codec_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // APB clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Host parallel port
  input  wire host_bus_t           host,
  output logic [7:0]               host_data_out,
  output logic                     host_data_oe,
  output logic                     play_req,
  output logic                     cap_req,
  // Converter side
  input  wire logic                conv_tick,
  input  wire logic [SAMPLE_W-1:0] adc_data,
  output logic [SAMPLE_W-1:0]      dac_data,
  // Mixer settings
  output mix_t                     mix
);
  if (DEPTH != FIFO_DEPTH) begin : g_chk
    $error("codec_host_port: FIFO depth is fixed at 16 samples");
  end

  // ************************************************************
  // APB register file
  // ************************************************************
  logic [4:0]  index_reg;
  logic [7:0]  ind_reg [32];
  logic        pready_reg, pslverr_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic [4:0]  cf_level, pf_level;

  wire setup    = psel && !penable;
  wire wr_en    = psel && penable && pready_reg && pwrite;
  wire hit_idx  = (paddr == OFF_INDEX);
  wire hit_dat  = (paddr == OFF_IDATA);
  wire hit_sta  = (paddr == OFF_STATUS);
  wire enh      = ind_reg[IX_MODE][B_ENH];
  // Bit4 of the pointer only counts in enhanced mode
  wire [4:0] eff_idx = {enh && index_reg[4], index_reg[3:0]};

  // Mode and path controls from indirect registers
  wire play_en = ind_reg[IX_CONFIG][B_PLAY_EN];
  wire cap_en  = ind_reg[IX_CONFIG][B_CAP_EN];
  wire hold    = ind_reg[IX_MISC][B_HOLD];
  wire b16     = ind_reg[IX_FORMAT][B_FMT16];
  wire bst     = ind_reg[IX_FORMAT][B_STEREO];
  wire [1:0] last_byte = {b16 && bst, b16 || bst}; // 1, 2 or 4 bytes

  // Read data selection, decoded in the setup cycle
  assign prdata_next = hit_idx ? {27'h0, index_reg} :
                       hit_dat ? {24'h0, ind_reg[eff_idx]} :
                       hit_sta ? {22'h0, cf_level, pf_level} : 32'h0;

  // Zero-wait answer: ready in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !(hit_idx || hit_dat || hit_sta);
      prdata_reg  <= setup ? prdata_next : 32'h0;
    end
  end

  // Index pointer, all five bits stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_reg <= 5'h00;
    end else if (wr_en && hit_idx) begin
      index_reg <= pwdata[4:0];
    end
  end

  // Indirect registers, one per entry
  for (genvar i = 0; i < 32; i++) begin : g_ind
    localparam logic [7:0] RV = (i == int'(IX_MODE)) ? RST_MODE : RST_IND;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ind_reg[i] <= RV;
      end else if (wr_en && hit_dat && eff_idx == 5'(i)) begin
        ind_reg[i] <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Mixer settings
  // ************************************************************
  mix_t mix_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_reg <= '0;
    end else begin
      mix_reg.line_vol      <= ind_reg[IX_LINE][4:0];
      mix_reg.line_mute     <= ind_reg[IX_LINE][B_LINE_MUT];
      mix_reg.mono_att      <= ind_reg[IX_MONO][3:0];
      mix_reg.mono_in_mute  <= ind_reg[IX_MONO][B_MIN_MUT];
      mix_reg.mono_out_mute <= ind_reg[IX_MONO][B_MONO_OUT_MUT];
    end
  end

  // ************************************************************
  // Host port strobe decode
  // ************************************************************
  logic prev_rd_reg, prev_wr_reg;
  wire rd_fall  = prev_rd_reg && !host.rd_n;
  wire wr_fall  = prev_wr_reg && !host.wr_n;
  wire any_ack  = !host.play_ack_n || !host.cap_ack_n;
  // Acknowledge overrides select and address
  wire pio      = !host.cs_n && !any_ack;
  wire pio_dat  = pio && host.addr == PIO_DATA;
  wire play_byte = play_en && wr_fall && (!host.play_ack_n || pio_dat);
  wire cap_byte  = cap_en && rd_fall && (!host.cap_ack_n || pio_dat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_rd_reg <= 1'b1;
      prev_wr_reg <= 1'b1;
    end else begin
      prev_rd_reg <= host.rd_n;
      prev_wr_reg <= host.wr_n;
    end
  end

  // ************************************************************
  // Playback path
  // ************************************************************
  logic [1:0]          pcnt_reg, ccnt_reg;
  logic [SAMPLE_W-1:0] psh_reg, dac_reg, pf_data, cf_data;
  logic                play_req_reg, cap_req_reg, pf_ready, pf_valid;
  logic                cf_ready, cf_valid;
  wire play_last = play_byte && pcnt_reg == last_byte;
  wire [SAMPLE_W-1:0] play_word =
    psh_reg | (SAMPLE_W'(host.data) << {pcnt_reg, 3'b000});
  wire play_pop = conv_tick && play_en;

  sample_fifo #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH)) u_play_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (play_last),
    .in_ready  (pf_ready),
    .in_data   (play_word),
    .out_valid (pf_valid),
    .out_ready (play_pop),
    .out_data  (pf_data),
    .level     (pf_level)
  );

  // Byte assembly, asynchronous host cycles never wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_reg <= 2'h0;
      psh_reg  <= '0;
    end else if (play_last || !play_en) begin
      pcnt_reg <= 2'h0;
      psh_reg  <= '0;
    end else if (play_byte) begin
      pcnt_reg <= pcnt_reg + 2'h1;
      psh_reg  <= play_word;
    end
  end

  // Request while room remains, held until last byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_req_reg <= 1'b0;
    end else if (play_last) begin
      play_req_reg <= 1'b0;
    end else if (!play_req_reg) begin
      play_req_reg <= play_en && pf_ready;
    end
  end

  // Converter feed with optional hold of the last sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_reg <= '0;
    end else if (play_pop) begin
      if (pf_valid) begin
        dac_reg <= pf_data;
      end else if (!hold) begin
        dac_reg <= '0;
      end
    end
  end

  // ************************************************************
  // Capture path
  // ************************************************************
  wire cap_last = cap_byte && ccnt_reg == last_byte;
  wire cap_push = conv_tick && cap_en;
  wire [7:0] cap_sel = 8'(cf_data >> {ccnt_reg, 3'b000});
  wire [7:0] stat_byte = {4'h0, cap_req_reg, play_req_reg, cf_valid, !pf_ready};
  logic [7:0]          dout_reg;
  logic                oe_reg;

  // Full FIFO refuses the push so stored samples stay intact
  sample_fifo #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH)) u_cap_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (cap_push),
    .in_ready  (cf_ready),
    .in_data   (adc_data),
    .out_valid (cf_valid),
    .out_ready (cap_last),
    .out_data  (cf_data),
    .level     (cf_level)
  );

  // Byte count and read data of the host port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccnt_reg  <= 2'h0;
      dout_reg  <= 8'h00;
      oe_reg    <= 1'b0;
    end else begin
      oe_reg <= !host.rd_n && (!host.cs_n || any_ack);
      if (cap_last || !cap_en) begin
        ccnt_reg <= 2'h0;
      end else if (cap_byte) begin
        ccnt_reg <= ccnt_reg + 2'h1;
      end
      if (rd_fall) begin
        dout_reg <= (cap_byte && cf_valid) ? cap_sel : stat_byte;
      end
    end
  end

  // Capture request while samples wait, held until last byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_req_reg <= 1'b0;
    end else if (cap_last) begin
      cap_req_reg <= 1'b0;
    end else if (!cap_req_reg) begin
      cap_req_reg <= cap_en && cf_valid;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign prdata        = prdata_reg;
  assign host_data_out = dout_reg;
  assign host_data_oe  = oe_reg;
  assign play_req      = play_req_reg;
  assign cap_req       = cap_req_reg;
  assign dac_data      = dac_reg;
  assign mix           = mix_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_legacy_index: assert property (@(posedge pclk) disable iff (!presetn)
    !enh |-> eff_idx[4] == 1'b0) else $error("bit4 decoded in legacy mode");
  a_enh_index: assert property (@(posedge pclk) disable iff (!presetn)
    enh && index_reg[4] |-> eff_idx == index_reg) else $error("bit4 not decoded");
  a_mode_back: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_dat && eff_idx == IX_MODE && !pwdata[B_ENH] |=> !enh)
    else $error("enhanced mode not left");
  a_mono_indep: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ind_reg[IX_MONO][B_MONO_OUT_MUT]) && $stable(ind_reg[IX_LINE])
    |=> $stable(mix_reg.line_mute)) else $error("line mute moved with mono");
  a_play_refill: assert property (@(posedge pclk) disable iff (!presetn)
    play_en && pf_ready && !play_req_reg && !play_last |=> play_req_reg)
    else $error("playback request missing");
  a_hold_last: assert property (@(posedge pclk) disable iff (!presetn)
    play_pop && !pf_valid && hold |=> $stable(dac_reg))
    else $error("held sample changed");
  a_cap_request: assert property (@(posedge pclk) disable iff (!presetn)
    cap_en && cf_valid && !cap_last |=> cap_req_reg) else $error("capture request missing");
  a_req_drop: assert property (@(posedge pclk) disable iff (!presetn)
    play_last |=> !play_req_reg) else $error("request not dropped");
  a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    cap_req_reg && !cap_last |=> cap_req_reg) else $error("request dropped early");
  a_cap_drop: assert property (@(posedge pclk) disable iff (!presetn)
    cap_push && !cf_ready && !cap_last |=> cf_level == 5'd16 && $stable(cf_data))
    else $error("full capture FIFO altered");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready_reg) else $error("APB answer late");

  c_play_full: cover property (@(posedge pclk) disable iff (!presetn) !pf_ready);
  c_play_hold: cover property (@(posedge pclk) disable iff (!presetn)
    play_pop && !pf_valid && hold);
  c_cap_over: cover property (@(posedge pclk) disable iff (!presetn)
    cap_push && !cf_ready);
endmodule : codec_host_port

// ### sim/host_model.sv
// Host bus model: PIO and DMA byte cycles toward the codec port
module host_model
  import codec_pkg::*;
(
  // Clock
  input  wire logic       pclk,
  // Codec port
  output host_bus_t       host,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  host_bus_t  drv;
  logic [7:0] last_data;

  // Wire level: the codec owns the data lines while it drives them
  always_comb begin
    host = drv;
    if (host_data_oe)
      host.data = host_data_out;
  end

  // Idle bus, strobes and acknowledges inactive
  initial begin
    drv       = '{1'b1, 1'b1, 1'b1, 2'h0, 1'b1, 1'b1, 8'hff};
    last_data = 8'h00;
  end

  // One byte cycle; kind 0 is PIO, 1 playback DMA, 2 capture DMA
  task automatic cycle(input int kind, input logic wr, input logic [1:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic oe);
    drv.cs_n       <= (kind != 0);
    drv.play_ack_n <= (kind != 1);
    drv.cap_ack_n  <= (kind != 2);
    drv.addr       <= a;
    drv.data       <= wr ? d : ~last_data;
    @(posedge pclk);
    drv.wr_n <= !wr;
    drv.rd_n <= wr;
    repeat (2) @(posedge pclk);
    q         = host_data_out;
    oe        = host_data_oe;
    last_data = wr ? d : q;
    drv.wr_n  <= 1'b1;
    drv.rd_n  <= 1'b1;
    @(posedge pclk);
    // Released lines never keep the last value
    drv.cs_n       <= 1'b1;
    drv.play_ack_n <= 1'b1;
    drv.cap_ack_n  <= 1'b1;
    drv.data       <= ~last_data;
    @(posedge pclk);
  endtask : cycle
endmodule : host_model

// ### sim/tb.sv
// Testbench for the codec host port block
module tb
  import codec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr, host_data_out, b;
  logic [31:0]         pwdata, prdata, rq, s;
  logic                re, o, conv_tick, host_data_oe, play_req, cap_req;
  logic [SAMPLE_W-1:0] adc_data, dac_data;
  host_bus_t           host;
  mix_t                mix;
  int                  fail_count, checks_done;

  codec_host_port #(.DEPTH(FIFO_DEPTH)) codec_host_port_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .host(host), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .play_req(play_req), .cap_req(cap_req), .conv_tick(conv_tick),
    .adc_data(adc_data), .dac_data(dac_data), .mix(mix));

  host_model host_model_i (.pclk(pclk), .host(host), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe));

  // ************************************************************
  // Clock, compare and bus tasks
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic ind_wr(input logic [4:0] ix, input logic [7:0] v);
    apb(1'b1, OFF_INDEX, 32'(ix));
    apb(1'b1, OFF_IDATA, 32'(v));
  endtask : ind_wr

  task automatic mix_is(input logic [11:0] exp, input string what);
    repeat (2) @(posedge pclk);
    chk32(32'(mix), 32'(exp), what);
  endtask : mix_is

  task automatic wait_hi(input logic cap);
    repeat (40) if ((cap ? cap_req : play_req) !== 1'b1) @(posedge pclk);
    chk32(32'(cap ? cap_req : play_req), 32'h1, "request raised");
  endtask : wait_hi

  task automatic tick(input logic [31:0] a);
    conv_tick <= 1'b1;
    adc_data  <= a;
    @(posedge pclk);
    conv_tick <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : tick

  function automatic logic [31:0] psmp(input int i);
    return {8'h5a, 8'(i), 8'hc3, 8'(~i)};
  endfunction : psmp

  function automatic logic [31:0] csmp(input int i);
    return {8'h3c, 8'(i), 8'h96, 8'(i * 3)};
  endfunction : csmp

  // Playback sample, four DMA bytes, low byte first
  task automatic send(input logic [31:0] v, input logic last);
    for (int k = 0; k < 4; k++) begin
      host_model_i.cycle(1, 1'b1, 2'h0, v[8*k+:8], b, o);
      if (k < 3) chk32(32'(play_req), 32'h1, "request held");
    end
    repeat (2) @(posedge pclk);
    if (last) chk32(32'(play_req), 32'h0, "full stops request");
  endtask : send

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    fail_count = 0;
    checks_done = 0;
    {presetn, psel, penable, pwrite, conv_tick} = 5'h0;
    {paddr, pwdata, adc_data} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state, legacy decode and unmapped access
    chk32(32'(mix), 32'h0, "mixer reset");
    chk32(32'({play_req, cap_req}), 32'h0, "requests idle");
    apb(1'b1, OFF_INDEX, 32'(IX_MODE));
    apb(1'b0, OFF_IDATA, 32'h0);
    chk32(rq, 32'(RST_MODE), "mode reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk32(32'(re), 32'h1, "unmapped error");
    ind_wr(IX_MONO, 8'h4f);
    mix_is(12'h000, "legacy alias");
    $display("test reset done");
    // Enhanced mode mixer fields
    ind_wr(IX_MODE, 8'h40);
    ind_wr(IX_LINE, 8'h1f);
    ind_wr(IX_MONO, 8'h4f);
    mix_is({5'h1f, 1'b0, 4'hf, 1'b0, 1'b1}, "mono out mute");
    ind_wr(IX_MONO, 8'h83);
    ind_wr(IX_LINE, 8'h80);
    mix_is({5'h00, 1'b1, 4'h3, 1'b1, 1'b0}, "mutes");
    ind_wr(IX_MODE, 8'h00);
    ind_wr(IX_MONO, 8'h00);
    mix_is({5'h00, 1'b1, 4'h3, 1'b1, 1'b0}, "legacy again");
    $display("test mode done");
    // Playback fill, refill and underrun
    ind_wr(IX_FORMAT, 8'h03);
    ind_wr(IX_CONFIG, 8'h01);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wait_hi(1'b0);
      send(psmp(i), i == FIFO_DEPTH - 1);
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    chk32(rq, 32'd16, "play level");
    host_model_i.cycle(0, 1'b0, 2'h2, 8'h00, b, o);
    chk32(32'(b), 32'h01, "pio status");
    tick(32'h0);
    chk32(dac_data, psmp(0), "first out");
    wait_hi(1'b0);
    send(psmp(16), 1'b1);
    // Misc sits above index 15, reachable only in enhanced mode
    ind_wr(IX_MODE, 8'h40);
    ind_wr(IX_MISC, 8'h80);
    for (int i = 1; i <= FIFO_DEPTH; i++) begin
      tick(32'h0);
      chk32(dac_data, psmp(i), "drain order");
    end
    tick(32'h0);
    chk32(dac_data, psmp(16), "hold last");
    ind_wr(IX_MISC, 8'h00);
    tick(32'h0);
    chk32(dac_data, 32'h0, "no hold");
    $display("test playback done");
    // Capture backlog, overflow and drain
    ind_wr(IX_CONFIG, 8'h02);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      tick(csmp(i));
      if (i == 0) wait_hi(1'b1);
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    chk32(rq, 32'd16 << 5, "cap level");
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      for (int k = 0; k < 4; k++) begin
        host_model_i.cycle(2, 1'b0, 2'h0, 8'h00, b, o);
        s[8*k+:8] = b;
        if (k < 3) chk32(32'(cap_req), 32'h1, "cap request held");
      end
      chk32(32'(o), 32'h1, "data drive");
      chk32(s, csmp(i), "capture order");
    end
    repeat (2) @(posedge pclk);
    chk32(32'(cap_req), 32'h0, "cap request drop");
    $display("test capture done");
    // PIO playback of one 16-bit mono sample, two bytes
    ind_wr(IX_FORMAT, 8'h01);
    ind_wr(IX_CONFIG, 8'h01);
    host_model_i.cycle(0, 1'b1, PIO_DATA, 8'h5a, b, o);
    host_model_i.cycle(0, 1'b1, PIO_DATA, 8'ha5, b, o);
    tick(32'h0);
    chk32(dac_data, 32'h0000a55a, "pio sample");
    $display("test pio done");
    complete_run();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule : tb
